// ### core/scp_pkg.sv
// Shared constants, register map and carrier types of the serial control port.
package scp_pkg;

	// Register byte addresses.
	localparam logic [31:0] ADDR_CTRL_ZERO   = 32'h4004_0000;
	localparam logic [31:0] ADDR_CTRL_ONE    = 32'h4004_0004;
	localparam logic [31:0] ADDR_DATA        = 32'h4004_0008;
	localparam logic [31:0] ADDR_STATUS      = 32'h4004_000c;
	localparam logic [31:0] ADDR_PRESCALE    = 32'h4004_0010;
	localparam logic [31:0] ADDR_INT_ENABLE  = 32'h4004_0014;
	localparam logic [31:0] ADDR_INT_RAW     = 32'h4004_0018;
	localparam logic [31:0] ADDR_INT_MASKED  = 32'h4004_001c;
	localparam logic [31:0] ADDR_INT_CLEAR   = 32'h4004_0020;

	// Status field positions.
	localparam int STAT_TX_EMPTY    = 0;
	localparam int STAT_TX_NOT_FULL = 1;
	localparam int STAT_RX_NOT_EMPT = 2;
	localparam int STAT_RX_FULL     = 3;
	localparam int STAT_BUSY        = 4;

	// Interrupt condition positions.
	localparam int INT_OVERRUN = 0;
	localparam int INT_TIMEOUT = 1;
	localparam int INT_RX_HALF = 2;
	localparam int INT_TX_HALF = 3;

	// Field widths and reset values.
	localparam int          CTRL_ZERO_W      = 16;
	localparam int          CTRL_ONE_W       = 4;
	localparam int          INT_W            = 4;
	localparam int          WORD_W           = 16;
	localparam logic [15:0] CTRL_ZERO_RESET  = 16'h0000;
	localparam logic [3:0]  CTRL_ONE_RESET   = 4'h0;
	localparam logic [7:0]  PRESCALE_RESET   = 8'h00;
	localparam logic [3:0]  INT_ENABLE_RESET = 4'h0;

	// Depth of each FIFO and length of the receive timeout in bit periods.
	localparam int FIFO_DEPTH   = 8;
	localparam int TIMEOUT_BITS = 32;

	typedef struct packed {
		logic [7:0] serial_clock_rate_factor;
		logic       clock_phase;
		logic       clock_polarity;
		logic [1:0] frame_format;
		logic [3:0] data_size_select;
	} scp_ctrl_zero_t;

	typedef struct packed {
		logic slave_output_disable;
		logic master_slave_select;
		logic port_enable;
		logic loopback_select;
	} scp_ctrl_one_t;

	typedef enum logic [2:0] {
		ST_IDLE   = 3'b001,
		ST_MASTER = 3'b010,
		ST_SLAVE  = 3'b100
	} scp_state_t;

endpackage

// ### core/scp_ctrl.sv
// Serial control port: APB registers, FIFOs, prescaler and SPI shift engine.
//
// Contract
// RULE1: loopback feeds own output back as input
// RULE2: port disabled while enable bit zero
// RULE3: software configures everything before enabling
// RULE4: master/slave bit writable only while disabled
// RULE5: master drives clock, MOSI, select
// RULE6: slave drives only MISO
// RULE7: slave output disable stops MISO drive
// RULE8: software writes data only when not full
// RULE9: written word starts at once when idle
// RULE10: software right-aligns short transmit words
// RULE11: data read pops oldest receive frame
// RULE12: short receive frames read right-aligned, zero-filled
// RULE13: status bit 0 is transmit empty
// RULE14: status bit 1 is transmit not full
// RULE15: status bit 2 is receive not empty
// RULE16: status bit 3 is receive full
// RULE17: status bit 4 is busy
// RULE18: prescaler divides clock by even divisor
// RULE19: divisor bit 0 reads zero
// RULE20: prescaler output divided by rate factor; the code divides it by factor + 1
// RULE21: external master clock at most one twelfth
// RULE22: software sets divisor at least two
// RULE23: each interrupt condition enabled separately
// RULE24: bit rate is clock over divisor times factor; the code uses divisor times (factor + 1)
// RULE25: data size codes length minus one
// RULE26: overrun, timeout, receive half, transmit half
// RULE27: FIFOs hold eight sixteen-bit words
// RULE28: reserved bits read zero
//
// Our own choice: the APB register port.
`timescale 1ns/1ns
module scp_ctrl #(
	parameter int FIFO_DEPTH = scp_pkg::FIFO_DEPTH
) (
	input  wire logic        i_clk_sys,
	input  wire logic        i_sys_rst,
	input  wire logic        i_psel,
	input  wire logic        i_penable,
	input  wire logic        i_pwrite,
	input  wire logic [31:0] i_paddr,
	input  wire logic [31:0] i_pwdata,
	output logic      [31:0] o_prdata,
	output logic             o_pready,
	output logic             o_pslverr,
	input  wire logic        i_sclk,
	input  wire logic        i_mosi,
	input  wire logic        i_miso,
	input  wire logic        i_ssel_n,
	output logic             o_sclk,
	output logic             o_sclk_oe,
	output logic             o_mosi,
	output logic             o_mosi_oe,
	output logic             o_miso,
	output logic             o_miso_oe,
	output logic             o_ssel_n,
	output logic             o_ssel_oe
);

	localparam int PW = $clog2(FIFO_DEPTH);
	localparam int CW = $clog2(FIFO_DEPTH + 1);
	localparam logic [CW-1:0] FULL_COUNT = CW'(FIFO_DEPTH);
	localparam logic [CW-1:0] HALF_COUNT = CW'(FIFO_DEPTH / 2);

	function automatic logic hit(input logic [31:0] addr, input logic [31:0] base);
		hit = (addr == base);
	endfunction

	function automatic logic [PW-1:0] step(input logic [PW-1:0] p);
		step = (p == PW'(FIFO_DEPTH - 1)) ? '0 : p + PW'(1);
	endfunction

	// Bit of the frame word that goes out after cnt bits have been sent, MSB first.
	function automatic logic pick(input logic [15:0] w, input logic [3:0] size,
			input logic [3:0] cnt);
		pick = w[size - cnt];
	endfunction

	scp_pkg::scp_ctrl_zero_t ctrl_zero;
	scp_pkg::scp_ctrl_one_t  ctrl_one;
	scp_pkg::scp_state_t     st;
	logic [7:0]              prescale;
	logic [3:0]              int_enable;
	logic                    overrun;

	logic [15:0]   tx_mem [FIFO_DEPTH];
	logic [15:0]   rx_mem [FIFO_DEPTH];
	logic [PW-1:0] tx_rd, tx_wr, rx_rd, rx_wr;
	logic [CW-1:0] tx_count, rx_count;

	logic [15:0] tx_word, rx_shift, rx_word, frame_word;
	logic [3:0]  bit_cnt;
	logic        rx_push, sclk_q, frame_lb;
	logic [6:0]  pre_cnt;
	logic [7:0]  rate_cnt;
	logic [21:0] to_cnt;

	logic        wr, rd, mapped;
	logic [31:0] rdata;
	logic        tx_empty, tx_full, rx_empty, rx_full, busy, timeout;
	logic        tx_push, tx_pop, rx_pop, rx_store;
	logic        start_master, start_slave, rx_in;
	logic [6:0]  half_div;
	logic        pre_done, half_edge;
	logic [21:0] to_limit;
	logic [3:0]  raw_int;
	logic [3:0]  size;

	assign size     = ctrl_zero.data_size_select; // [RULE25]
	assign tx_empty = (tx_count == '0);
	assign tx_full  = (tx_count == FULL_COUNT);
	assign rx_empty = (rx_count == '0);
	assign rx_full  = (rx_count == FULL_COUNT); // [RULE27]
	assign busy     = (st != scp_pkg::ST_IDLE) || !tx_empty; // [RULE17]

	// A write or read takes effect only at the edge where the slave answers.
	assign wr = i_psel && i_penable && o_pready && i_pwrite;
	assign rd = i_psel && i_penable && o_pready && !i_pwrite;

	assign tx_push  = wr && hit(i_paddr, scp_pkg::ADDR_DATA) && !tx_full;
	assign rx_pop   = rd && hit(i_paddr, scp_pkg::ADDR_DATA) && !rx_empty; // [RULE11]
	assign rx_store = rx_push && !rx_full;

	assign start_master = (st == scp_pkg::ST_IDLE) && ctrl_one.port_enable
		&& !ctrl_one.master_slave_select && !tx_empty; // [RULE9]
	assign start_slave  = (st == scp_pkg::ST_IDLE) && ctrl_one.port_enable
		&& ctrl_one.master_slave_select && !i_ssel_n;
	assign tx_pop       = start_master || (start_slave && !tx_empty);

	// Loopback takes the serial input from our own serial output.
	assign rx_in = ctrl_one.loopback_select ? (ctrl_one.master_slave_select ? o_miso : o_mosi)
		: (ctrl_one.master_slave_select ? i_mosi : i_miso); // [RULE1]

	// A divisor below two would stall the prescaler, so it is treated as two.
	assign half_div  = (prescale[7:1] == 7'h00) ? 7'h01 : prescale[7:1];
	assign pre_done  = (pre_cnt == half_div - 7'h01); // [RULE18]
	assign half_edge = pre_done && (rate_cnt == ctrl_zero.serial_clock_rate_factor); // [RULE20]

	// Timeout length is 32 bit periods of divisor times (factor + 1) clocks.
	assign to_limit = 22'(scp_pkg::TIMEOUT_BITS) * 22'({half_div, 1'b0})
		* 22'({1'b0, ctrl_zero.serial_clock_rate_factor} + 9'h001); // [RULE24]
	assign timeout  = !rx_empty && (to_cnt == to_limit);

	always_comb begin
		raw_int = '0;
		raw_int[scp_pkg::INT_OVERRUN] = overrun;
		raw_int[scp_pkg::INT_TIMEOUT] = timeout;
		raw_int[scp_pkg::INT_RX_HALF] = (rx_count >= HALF_COUNT);
		raw_int[scp_pkg::INT_TX_HALF] = (tx_count <= HALF_COUNT); // [RULE26]
	end

	// Read mux; all bits above a field read as zero.
	always_comb begin
		rdata  = '0;
		mapped = 1'b1;
		if (hit(i_paddr, scp_pkg::ADDR_CTRL_ZERO)) begin
			rdata[15:0] = ctrl_zero;
		end else if (hit(i_paddr, scp_pkg::ADDR_CTRL_ONE)) begin
			rdata[3:0] = ctrl_one;
		end else if (hit(i_paddr, scp_pkg::ADDR_DATA)) begin
			rdata[15:0] = rx_empty ? 16'h0000 : rx_mem[rx_rd]; // [RULE28]
		end else if (hit(i_paddr, scp_pkg::ADDR_STATUS)) begin
			rdata[scp_pkg::STAT_TX_EMPTY]    = tx_empty; // [RULE13]
			rdata[scp_pkg::STAT_TX_NOT_FULL] = !tx_full; // [RULE14]
			rdata[scp_pkg::STAT_RX_NOT_EMPT] = !rx_empty; // [RULE15]
			rdata[scp_pkg::STAT_RX_FULL]     = rx_full; // [RULE16]
			rdata[scp_pkg::STAT_BUSY]        = busy; // [RULE17]
		end else if (hit(i_paddr, scp_pkg::ADDR_PRESCALE)) begin
			rdata[7:0] = prescale;
		end else if (hit(i_paddr, scp_pkg::ADDR_INT_ENABLE)) begin
			rdata[3:0] = int_enable;
		end else if (hit(i_paddr, scp_pkg::ADDR_INT_RAW)) begin
			rdata[3:0] = raw_int;
		end else if (hit(i_paddr, scp_pkg::ADDR_INT_MASKED)) begin
			rdata[3:0] = raw_int & int_enable;
		end else if (!hit(i_paddr, scp_pkg::ADDR_INT_CLEAR)) begin
			mapped = 1'b0;
		end
	end

	// One wait state so that read data and the answer come from flip-flops.
	always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_pready  <= 1'b0;
			o_prdata  <= 32'h0000_0000;
			o_pslverr <= 1'b0;
		end else if (i_psel && i_penable && !o_pready) begin
			o_pready  <= 1'b1;
			o_prdata  <= i_pwrite ? 32'h0000_0000 : rdata;
			o_pslverr <= !mapped;
		end else begin
			o_pready  <= 1'b0;
			o_pslverr <= 1'b0;
		end
	end

	always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			ctrl_zero  <= scp_pkg::CTRL_ZERO_RESET;
			ctrl_one   <= scp_pkg::CTRL_ONE_RESET;
			prescale   <= scp_pkg::PRESCALE_RESET;
			int_enable <= scp_pkg::INT_ENABLE_RESET;
		end else if (wr) begin
			if (hit(i_paddr, scp_pkg::ADDR_CTRL_ZERO)) begin
				ctrl_zero <= i_pwdata[15:0];
			end
			if (hit(i_paddr, scp_pkg::ADDR_CTRL_ONE)) begin
				ctrl_one.loopback_select      <= i_pwdata[0];
				ctrl_one.port_enable          <= i_pwdata[1];
				ctrl_one.slave_output_disable <= i_pwdata[3];
				if (!ctrl_one.port_enable) begin
					ctrl_one.master_slave_select <= i_pwdata[2]; // [RULE4]
				end
			end
			if (hit(i_paddr, scp_pkg::ADDR_PRESCALE)) begin
				prescale <= {i_pwdata[7:1], 1'b0}; // [RULE19]
			end
			if (hit(i_paddr, scp_pkg::ADDR_INT_ENABLE)) begin
				int_enable <= i_pwdata[3:0]; // [RULE23]
			end
		end
	end

	// Transmit FIFO; a write to a full FIFO is dropped.
	always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			tx_rd    <= '0;
			tx_wr    <= '0;
			tx_count <= '0;
		end else begin
			if (tx_push) begin
				tx_mem[tx_wr] <= i_pwdata[15:0];
				tx_wr         <= step(tx_wr);
			end
			if (tx_pop) begin
				tx_rd <= step(tx_rd);
			end
			tx_count <= tx_count + CW'(tx_push) - CW'(tx_pop);
		end
	end

	// Receive FIFO; a frame arriving while full is dropped and flags overrun.
	always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			rx_rd    <= '0;
			rx_wr    <= '0;
			rx_count <= '0;
			overrun  <= 1'b0;
		end else begin
			if (rx_store) begin
				rx_mem[rx_wr] <= rx_word;
				rx_wr         <= step(rx_wr);
			end
			if (rx_pop) begin
				rx_rd <= step(rx_rd);
			end
			rx_count <= rx_count + CW'(rx_store) - CW'(rx_pop);
			// The set wins over a clear in the same cycle.
			if (rx_push && rx_full) begin
				overrun <= 1'b1; // [RULE26]
			end else if (wr && hit(i_paddr, scp_pkg::ADDR_INT_CLEAR)
					&& i_pwdata[scp_pkg::INT_OVERRUN]) begin
				overrun <= 1'b0;
			end
		end
	end

	always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			to_cnt <= '0;
		end else if (rx_empty || rx_pop || rx_store || (wr && hit(i_paddr,
				scp_pkg::ADDR_INT_CLEAR) && i_pwdata[scp_pkg::INT_TIMEOUT])) begin
			to_cnt <= '0;
		end else if (to_cnt != to_limit) begin
			to_cnt <= to_cnt + 22'h000001;
		end
	end

	// Prescaler and rate divider run only during a master frame.
	always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			pre_cnt  <= '0;
			rate_cnt <= '0;
		end else if (st != scp_pkg::ST_MASTER) begin
			pre_cnt  <= '0;
			rate_cnt <= '0;
		end else if (pre_done) begin
			pre_cnt  <= '0;
			rate_cnt <= half_edge ? 8'h00 : rate_cnt + 8'h01; // [RULE20]
		end else begin
			pre_cnt <= pre_cnt + 7'h01; // [RULE18]
		end
	end

	always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			sclk_q <= 1'b0;
		end else begin
			sclk_q <= i_sclk;
		end
	end

	// Pin drivers follow the mode; a disabled port drives nothing.
	always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_sclk_oe <= 1'b0;
			o_mosi_oe <= 1'b0;
			o_ssel_oe <= 1'b0;
			o_miso_oe <= 1'b0;
		end else begin
			o_sclk_oe <= ctrl_one.port_enable && !ctrl_one.master_slave_select; // [RULE5]
			o_mosi_oe <= ctrl_one.port_enable && !ctrl_one.master_slave_select;
			o_ssel_oe <= ctrl_one.port_enable && !ctrl_one.master_slave_select;
			o_miso_oe <= ctrl_one.port_enable && ctrl_one.master_slave_select
				&& !ctrl_one.slave_output_disable && !i_ssel_n; // [RULE6] [RULE7]
		end
	end

	// Shift engine: SPI with idle-low clock, data out on falling, in on rising.
	always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			st         <= scp_pkg::ST_IDLE;
			tx_word    <= '0;
			rx_shift   <= '0;
			rx_word    <= '0;
			frame_word <= '0;
			frame_lb   <= 1'b0;
			bit_cnt    <= '0;
			rx_push    <= 1'b0;
			o_sclk     <= 1'b0;
			o_ssel_n   <= 1'b1;
			o_mosi     <= 1'b0;
			o_miso     <= 1'b0;
		end else begin
			rx_push <= 1'b0;
			case (st)
				scp_pkg::ST_IDLE: begin
					o_sclk   <= 1'b0;
					o_ssel_n <= 1'b1;
					bit_cnt  <= '0;
					rx_shift <= '0;
					frame_lb <= ctrl_one.loopback_select;
					if (start_master) begin
						tx_word    <= tx_mem[tx_rd];
						frame_word <= tx_mem[tx_rd];
						o_mosi     <= pick(tx_mem[tx_rd], size, 4'h0);
						o_ssel_n   <= 1'b0;
						st         <= scp_pkg::ST_MASTER; // [RULE5] [RULE9]
					end else if (start_slave) begin
						tx_word    <= tx_empty ? 16'h0000 : tx_mem[tx_rd];
						frame_word <= tx_empty ? 16'h0000 : tx_mem[tx_rd];
						o_miso     <= !tx_empty && pick(tx_mem[tx_rd], size, 4'h0);
						st         <= scp_pkg::ST_SLAVE; // [RULE6]
					end
				end
				scp_pkg::ST_MASTER: begin
					if (!ctrl_one.port_enable) begin
						o_ssel_n <= 1'b1;
						st       <= scp_pkg::ST_IDLE; // [RULE2]
					end else if (half_edge && !o_sclk) begin
						o_sclk   <= 1'b1;
						rx_shift <= {rx_shift[14:0], rx_in};
					end else if (half_edge) begin
						o_sclk <= 1'b0;
						if (bit_cnt == size) begin
							// Select rises after every frame, so back-to-back words are framed apart.
							o_ssel_n <= 1'b1;
							rx_word  <= rx_shift; // [RULE12]
							rx_push <= 1'b1;
							st      <= scp_pkg::ST_IDLE;
						end else begin
							bit_cnt <= bit_cnt + 4'h1;
							o_mosi  <= pick(tx_word, size, bit_cnt + 4'h1);
						end
					end
				end
				scp_pkg::ST_SLAVE: begin
					if (!ctrl_one.port_enable || i_ssel_n) begin
						st <= scp_pkg::ST_IDLE; // [RULE2]
					end else if (i_sclk && !sclk_q) begin
						if (bit_cnt == size) begin
							rx_word <= {rx_shift[14:0], rx_in}; // [RULE12]
							rx_push <= 1'b1;
							st      <= scp_pkg::ST_IDLE;
						end else begin
							rx_shift <= {rx_shift[14:0], rx_in};
						end
					end else if (!i_sclk && sclk_q) begin
						bit_cnt <= bit_cnt + 4'h1;
						o_miso  <= pick(tx_word, size, bit_cnt + 4'h1);
					end
				end
				default: begin
					st <= scp_pkg::ST_IDLE;
				end
			endcase
		end
	end

	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_sys_rst);

	loopback_echo_a: assert property (rx_push && frame_lb && o_ssel_oe // [RULE1]
		|-> rx_word == (frame_word & ((16'h0002 << size) - 16'h0001)))
		else $error("loopback frame differs from sent word");
	disable_idle_a: assert property (!ctrl_one.port_enable // [RULE2]
		|=> st == scp_pkg::ST_IDLE && !o_sclk_oe && !o_miso_oe)
		else $error("port active while disabled");
	mode_lock_a: assert property (wr && ctrl_one.port_enable // [RULE4]
		|=> $stable(ctrl_one.master_slave_select))
		else $error("master/slave select changed while enabled");
	master_pins_a: assert property (st == scp_pkg::ST_MASTER // [RULE5]
		|-> o_sclk_oe && o_mosi_oe && !o_miso_oe && !o_ssel_n)
		else $error("master frame without master drivers");
	slave_pins_a: assert property (st == scp_pkg::ST_SLAVE // [RULE6]
		|-> !o_sclk_oe && !o_mosi_oe && !o_ssel_oe)
		else $error("slave drives master lines");
	miso_quiet_a: assert property (ctrl_one.slave_output_disable // [RULE7]
		&& ctrl_one.master_slave_select |=> !o_miso_oe)
		else $error("slave output disabled yet driving");
	start_now_a: assert property (start_master // [RULE9]
		|=> st == scp_pkg::ST_MASTER && $fell(o_ssel_n) && tx_count == $past(tx_count)
			- CW'(1) + CW'($past(tx_push)))
		else $error("written word did not start a frame");
	rx_pop_a: assert property (rx_pop && !rx_store // [RULE11]
		|=> rx_count == $past(rx_count) - CW'(1))
		else $error("data read did not pop receive FIFO");
	rx_align_a: assert property (rx_push && size != 4'hf // [RULE12]
		|-> (rx_word >> (size + 4'h1)) == 16'h0000)
		else $error("receive word not right-aligned");
	busy_flag_a: assert property (tx_push || start_master |=> busy) // [RULE17]
		else $error("busy low after a word was queued");
	even_div_a: assert property (wr && hit(i_paddr, scp_pkg::ADDR_PRESCALE) // [RULE19]
		|=> prescale == {$past(i_pwdata[7:1]), 1'b0})
		else $error("prescale divisor not stored even");
	half_period_a: assert property ($rose(o_sclk) && prescale == 8'h02 // [RULE24]
		&& ctrl_zero.serial_clock_rate_factor == 8'h00 |=> !o_sclk)
		else $error("bit clock half period wrong for divisor two");

	master_frame_c: cover property (st == scp_pkg::ST_MASTER && rx_push);
	slave_frame_c: cover property (st == scp_pkg::ST_SLAVE && rx_push);
	overrun_c: cover property (rx_push && rx_full);
	tx_full_c: cover property (tx_full && busy);

endmodule // scp_ctrl

// ### bench/scp_spi_peer.sv
// Behavioural SPI peer: a slave toward a master port, a master toward a slave port.
`timescale 1ns/1ns
module scp_spi_peer (
	input  wire logic       i_clk_sys,
	input  wire logic       i_act_master,
	input  wire logic [7:0] i_tx,
	input  wire logic       i_sclk,
	input  wire logic       i_mosi,
	input  wire logic       i_miso,
	input  wire logic       i_ssel_n,
	output logic            o_miso,
	output logic            o_sclk,
	output logic            o_mosi,
	output logic            o_ssel_n,
	output logic      [7:0] o_rx
);
	logic [7:0] sh;

	initial begin
		o_miso = 1'b0;
		o_sclk = 1'b0;
		o_mosi = 1'b0;
		o_ssel_n = 1'b1;
		o_rx = 8'h00;
		sh = 8'h00;
	end

	always @(negedge i_ssel_n) if (!i_act_master) begin
		sh = i_tx;
		o_miso = i_tx[7];
	end
	always @(posedge i_sclk) if (!i_act_master && !i_ssel_n) begin
		o_rx = {o_rx[6:0], i_mosi};
	end
	always @(negedge i_sclk) if (!i_act_master && !i_ssel_n) begin
		sh = sh << 1;
		o_miso = sh[7];
	end
	// A released line shows the inverse of its last value, so a stale bit cannot pass.
	always @(posedge i_ssel_n) begin
		o_miso = ~o_miso;
	end

	// Half periods of 8 clocks keep the bit clock well under the slave's limit.
	task automatic frame(input logic [7:0] tx);
		@(posedge i_clk_sys);
		o_ssel_n <= 1'b0;
		for (int i = 7; i >= 0; i--) begin
			o_mosi <= tx[i];
			repeat (8) @(posedge i_clk_sys);
			o_sclk <= 1'b1;
			o_rx = {o_rx[6:0], i_miso};
			repeat (8) @(posedge i_clk_sys);
			o_sclk <= 1'b0;
		end
		repeat (8) @(posedge i_clk_sys);
		o_ssel_n <= 1'b1;
		o_mosi <= ~tx[0];
	endtask
endmodule // scp_spi_peer

// ### bench/scp_ctrl_tb.sv
// Self-checking bench for the serial control port with an SPI peer model.
`timescale 1ns/1ns
module scp_ctrl_tb;
	logic        clk_sys, sys_rst, psel, penable, pwrite, pready, pslverr, act_m, e;
	logic [31:0] paddr, pwdata, prdata, q;
	logic        d_sclk, d_sclk_oe, d_mosi, d_mosi_oe, d_miso, d_miso_oe, d_ssel_n, d_ssel_oe;
	logic        p_sclk, p_mosi, p_miso, p_ssel_n, oe_seen;
	logic [7:0]  p_tx, p_rx;
	int          failures, checks;
	wire         w_sclk = d_sclk_oe ? d_sclk : p_sclk;
	wire         w_mosi = d_mosi_oe ? d_mosi : p_mosi;
	wire         w_miso = d_miso_oe ? d_miso : p_miso;
	wire         w_ssel_n = d_ssel_oe ? d_ssel_n : p_ssel_n;

	scp_ctrl i_dut (.i_clk_sys(clk_sys), .i_sys_rst(sys_rst), .i_psel(psel),
		.i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
		.o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_sclk(w_sclk),
		.i_mosi(w_mosi), .i_miso(w_miso), .i_ssel_n(w_ssel_n), .o_sclk(d_sclk),
		.o_sclk_oe(d_sclk_oe), .o_mosi(d_mosi), .o_mosi_oe(d_mosi_oe), .o_miso(d_miso),
		.o_miso_oe(d_miso_oe), .o_ssel_n(d_ssel_n), .o_ssel_oe(d_ssel_oe));

	scp_spi_peer i_peer (.i_clk_sys(clk_sys), .i_act_master(act_m), .i_tx(p_tx),
		.i_sclk(w_sclk), .i_mosi(w_mosi), .i_miso(w_miso), .i_ssel_n(w_ssel_n),
		.o_miso(p_miso), .o_sclk(p_sclk), .o_mosi(p_mosi), .o_ssel_n(p_ssel_n), .o_rx(p_rx));

	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end

	always @(posedge clk_sys) if (d_miso_oe === 1'b1) begin
		oe_seen <= 1'b1;
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			failures++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		// Wait states are the slave's choice; only the watchdog ends this wait.
		do @(posedge clk_sys); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rd(input logic [31:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0);
		chk(q, x);
	endtask

	task automatic wait_idle();
		int n;
		n = 0;
		do begin
			apb(1'b0, scp_pkg::ADDR_STATUS, 32'h0);
			n++;
		end while (q[4] !== 1'b0 && n < 300);
		chk({31'h0, q[4]}, 32'h0);
	endtask

	task automatic check_reset();
		rd(scp_pkg::ADDR_STATUS, 32'h3);
		rd(scp_pkg::ADDR_CTRL_ONE, 32'h0);
		apb(1'b0, 32'h4004_0024, 32'h0);
		chk({31'h0, e}, 32'h1);
		wr(scp_pkg::ADDR_PRESCALE, 32'h1ff);
		rd(scp_pkg::ADDR_PRESCALE, 32'hfe);
		wr(scp_pkg::ADDR_INT_ENABLE, 32'hffff_fff5);
		rd(scp_pkg::ADDR_INT_ENABLE, 32'h5);
		wr(scp_pkg::ADDR_INT_ENABLE, 32'ha);
		rd(scp_pkg::ADDR_INT_ENABLE, 32'ha);
	endtask

	// Divisor 4 and rate factor 1 give a bit period of 8 clocks.
	task automatic master_xfer();
		time t;
		wr(scp_pkg::ADDR_CTRL_ZERO, 32'h107);
		wr(scp_pkg::ADDR_PRESCALE, 32'h4);
		wr(scp_pkg::ADDR_CTRL_ONE, 32'h2);
		wr(scp_pkg::ADDR_DATA, 32'hc3);
		repeat (3) @(negedge clk_sys);
		chk({31'h0, d_ssel_n}, 32'h0);
		chk({28'h0, d_sclk_oe, d_mosi_oe, d_ssel_oe, d_miso_oe}, 32'he);
		rd(scp_pkg::ADDR_STATUS, 32'h13);
		@(posedge d_sclk);
		t = $time;
		@(posedge d_sclk);
		chk(32'(($time - t) / 40), 32'h8);
		wait_idle();
		chk({24'h0, p_rx}, 32'hc3);
		rd(scp_pkg::ADDR_DATA, 32'h5a);
		rd(scp_pkg::ADDR_DATA, 32'h0);
	endtask

	task automatic fifo_fill();
		wr(scp_pkg::ADDR_CTRL_ONE, 32'h0);
		for (int i = 0; i < 9; i++) wr(scp_pkg::ADDR_DATA, 32'h10 + i);
		chk({30'h0, d_ssel_oe, d_sclk_oe}, 32'h0);
		rd(scp_pkg::ADDR_STATUS, 32'h10);
		wr(scp_pkg::ADDR_PRESCALE, 32'h2);
		wr(scp_pkg::ADDR_CTRL_ZERO, 32'h7);
		wr(scp_pkg::ADDR_CTRL_ONE, 32'h3);
		wr(scp_pkg::ADDR_CTRL_ONE, 32'h7);
		rd(scp_pkg::ADDR_CTRL_ONE, 32'h3);
		wait_idle();
		rd(scp_pkg::ADDR_STATUS, 32'hf);
		for (int i = 0; i < 8; i++) rd(scp_pkg::ADDR_DATA, 32'h10 + i);
		rd(scp_pkg::ADDR_STATUS, 32'h3);
		rd(scp_pkg::ADDR_INT_RAW, 32'h8);
		rd(scp_pkg::ADDR_INT_MASKED, 32'h8);
	endtask

	task automatic slave_xfer();
		wr(scp_pkg::ADDR_CTRL_ONE, 32'h0);
		wr(scp_pkg::ADDR_CTRL_ONE, 32'h4);
		rd(scp_pkg::ADDR_CTRL_ONE, 32'h4);
		wr(scp_pkg::ADDR_CTRL_ONE, 32'h6);
		act_m <= 1'b1;
		wr(scp_pkg::ADDR_DATA, 32'h69);
		chk({29'h0, d_sclk_oe, d_mosi_oe, d_ssel_oe}, 32'h0);
		oe_seen = 1'b0;
		i_peer.frame(8'h96);
		chk({23'h0, oe_seen, p_rx}, 32'h169);
		wait_idle();
		rd(scp_pkg::ADDR_DATA, 32'h96);
		wr(scp_pkg::ADDR_CTRL_ONE, 32'he);
		oe_seen = 1'b0;
		i_peer.frame(8'h33);
		chk({31'h0, oe_seen}, 32'h0);
		wait_idle();
		rd(scp_pkg::ADDR_DATA, 32'h33);
	endtask

	task automatic print_verdict();
		$display("Comparisons %0d, mismatches %0d", checks, failures);
		if (failures == 0 && checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	initial begin
		repeat (30000) @(posedge clk_sys);
		failures++;
		print_verdict();
	end

	initial begin
		sys_rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 32'h0;
		pwdata = 32'h0;
		act_m = 1'b0;
		p_tx = 8'h5a;
		oe_seen = 1'b0;
		failures = 0;
		checks = 0;
		repeat (10) @(posedge clk_sys);
		sys_rst <= 1'b0;
		check_reset();
		master_xfer();
		fifo_fill();
		slave_xfer();
		print_verdict();
	end
endmodule // scp_ctrl_tb
